// >>> hdl/tone_device.sv
`timescale 1ns/1ps
`default_nettype none
`include "tone_defs.svh"

module tone_device (
   input wire logic hclk,
   input wire logic hresetn,
   i2c_link_if.device link,
   output logic [14:0] ear1_word,
   output logic [14:0] ear2_word,
   output logic buzzer_pdm_out,
   output logic sample_tick
);

   // ************************************************************
   // Link input synchronisers and bus conditions
   // ************************************************************
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   logic scl_d_ff;
   logic sda_d_ff;
   wire scl_s = scl_sync_ff[1];
   wire sda_s = sda_sync_ff[1];
   wire scl_rise = scl_s & ~scl_d_ff;
   wire scl_fall = ~scl_s & scl_d_ff;
   wire start_det = scl_s & scl_d_ff & sda_d_ff & ~sda_s;
   wire stop_det = scl_s & scl_d_ff & ~sda_d_ff & sda_s;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
         scl_d_ff <= 1'b1;
         sda_d_ff <= 1'b1;
      end
      else
      begin
         scl_sync_ff <= {scl_sync_ff[0], link.scl};
         sda_sync_ff <= {sda_sync_ff[0], link.sda};
         scl_d_ff <= scl_s;
         sda_d_ff <= sda_s;
      end
   end

   // ************************************************************
   // Serial slave state machine
   // ************************************************************
   tone_pkg::dev_state_t st_ff;
   tone_pkg::dev_state_t nxt_st;
   logic [3:0] cnt_ff;
   logic [3:0] nxt_cnt;
   logic [7:0] sh_ff;
   logic [7:0] nxt_sh;
   logic [2:0] ptr_ff;
   logic [2:0] nxt_ptr;
   logic [1:0] nbyte_ff;
   logic [1:0] nxt_nbyte;
   logic rw_ff;
   logic nxt_rw;
   logic drv_ff;
   logic nxt_drv;
   logic nack_ff;
   logic nxt_nack;
   logic [7:0] regs_ff [`REG_COUNT];
   wire ptr_ok = ptr_ff < 3'(`REG_COUNT);
   wire [7:0] rd_byte = ptr_ok ? regs_ff[ptr_ff] : 8'h00;
   wire byte_done = scl_fall && cnt_ff == 4'h8;
   // Write strobe on the fall that closes a data byte of a write.
   wire wr_en = st_ff == tone_pkg::d_rx && byte_done && nbyte_ff == 2'h2 && !rw_ff;

   // The device only ever pulls the data line; the clock is never driven.
   assign link.sda_d_o = 1'b0;
   assign link.sda_d_oe = drv_ff;

   always_comb
   begin
      nxt_st = st_ff;
      nxt_cnt = cnt_ff;
      nxt_sh = sh_ff;
      nxt_ptr = ptr_ff;
      nxt_nbyte = nbyte_ff;
      nxt_rw = rw_ff;
      nxt_drv = drv_ff;
      nxt_nack = nack_ff;
      if (stop_det)
      begin
         nxt_st = tone_pkg::d_idle;
         nxt_drv = 1'b0;
      end
      else if (start_det)
      begin
         nxt_st = tone_pkg::d_rx;
         nxt_cnt = 4'h0;
         nxt_nbyte = 2'h0;
         nxt_drv = 1'b0;
      end
      else
      begin
         case (st_ff)
            tone_pkg::d_rx:
            begin
               if (scl_rise)
               begin
                  nxt_sh = {sh_ff[6:0], sda_s};
                  nxt_cnt = cnt_ff + 4'h1;
               end
               else if (byte_done)
               begin
                  nxt_cnt = 4'h0;
                  nxt_st = tone_pkg::d_ack;
                  nxt_drv = 1'b1;
                  if (nbyte_ff == 2'h0)
                  begin
                     nxt_rw = sh_ff[0];
                     if (sh_ff[7:1] != `DEV_ADDR7)
                     begin
                        nxt_st = tone_pkg::d_idle;
                        nxt_drv = 1'b0;
                     end
                  end
                  else if (nbyte_ff == 2'h1)
                     nxt_ptr = sh_ff[2:0];
                  else
                     nxt_ptr = ptr_ff + 3'h1;
                  if (nbyte_ff != 2'h2)
                     nxt_nbyte = nbyte_ff + 2'h1;
               end
            end
            tone_pkg::d_ack:
            begin
               // Low is held until the fall that ends the acknowledge pulse.
               if (scl_fall)
               begin
                  nxt_cnt = 4'h0;
                  if (rw_ff)
                  begin
                     nxt_st = tone_pkg::d_tx;
                     nxt_sh = rd_byte;
                     nxt_drv = ~rd_byte[7];
                  end
                  else
                  begin
                     nxt_st = tone_pkg::d_rx;
                     nxt_drv = 1'b0;
                  end
               end
            end
            tone_pkg::d_tx:
            begin
               if (scl_fall)
               begin
                  if (cnt_ff == 4'h7)
                  begin
                     nxt_st = tone_pkg::d_ain;
                     nxt_drv = 1'b0;
                     nxt_ptr = ptr_ff + 3'h1;
                  end
                  else
                  begin
                     nxt_sh = {sh_ff[6:0], 1'b0};
                     nxt_drv = ~sh_ff[6];
                     nxt_cnt = cnt_ff + 4'h1;
                  end
               end
            end
            tone_pkg::d_ain:
            begin
               if (scl_rise)
                  nxt_nack = sda_s;
               else if (scl_fall)
               begin
                  nxt_cnt = 4'h0;
                  if (nack_ff)
                     nxt_st = tone_pkg::d_idle;
                  else
                  begin
                     nxt_st = tone_pkg::d_tx;
                     nxt_sh = rd_byte;
                     nxt_drv = ~rd_byte[7];
                  end
               end
            end
            default:
               nxt_drv = 1'b0;
         endcase
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_ff <= tone_pkg::d_idle;
         cnt_ff <= 4'h0;
         sh_ff <= 8'h00;
         ptr_ff <= 3'h0;
         nbyte_ff <= 2'h0;
         rw_ff <= 1'b0;
         drv_ff <= 1'b0;
         nack_ff <= 1'b0;
      end
      else
      begin
         st_ff <= nxt_st;
         cnt_ff <= nxt_cnt;
         sh_ff <= nxt_sh;
         ptr_ff <= nxt_ptr;
         nbyte_ff <= nxt_nbyte;
         rw_ff <= nxt_rw;
         drv_ff <= nxt_drv;
         nack_ff <= nxt_nack;
      end
   end

   // ************************************************************
   // Control registers
   // ************************************************************
   for (genvar i = 0; i < `REG_COUNT; i++)
   begin : g_reg
      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
            regs_ff[i] <= (i == 0) ? `REG_PWR_RST : `REG_RST;
         else if (wr_en && ptr_ff == 3'(i))
            regs_ff[i] <= sh_ff;
      end
   end

   // ************************************************************
   // Tone generator
   // ************************************************************
   localparam int SAMPLE_DIV = `CLK_MHZ * 1000000 / `SAMPLE_HZ;
   logic [11:0] div_ff;
   wire tick = div_ff == 12'(SAMPLE_DIV - 1);
   assign sample_tick = tick;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
         div_ff <= 12'h000;
      else
         div_ff <= tick ? 12'h000 : div_ff + 12'h001;
   end

   // Quarter-wave table; the upper amplitude is about 2 dB above the lower.
   function automatic logic signed [6:0] sine_lu(input logic [9:0] ph, input logic big);
      logic [3:0] k;
      logic [5:0] m;
      k = ph[8] ? ~ph[7:4] : ph[7:4];
      case (k)
         4'h0: m = big ? 6'h02 : 6'h02;
         4'h1: m = big ? 6'h06 : 6'h05;
         4'h2: m = big ? 6'h09 : 6'h08;
         4'h3: m = big ? 6'h0D : 6'h0A;
         4'h4: m = big ? 6'h11 : 6'h0D;
         4'h5: m = big ? 6'h14 : 6'h10;
         4'h6: m = big ? 6'h17 : 6'h12;
         4'h7: m = big ? 6'h1A : 6'h15;
         4'h8: m = big ? 6'h1D : 6'h17;
         4'h9: m = big ? 6'h1F : 6'h19;
         4'hA: m = big ? 6'h21 : 6'h1B;
         4'hB: m = big ? 6'h23 : 6'h1C;
         4'hC: m = big ? 6'h25 : 6'h1D;
         4'hD: m = big ? 6'h26 : 6'h1E;
         4'hE: m = big ? 6'h27 : 6'h1F;
         default: m = big ? 6'h27 : 6'h1F;
      endcase
      sine_lu = ph[9] ? -$signed({1'b0, m}) : $signed({1'b0, m});
   endfunction

   logic [9:0] ph_ff [2];
   logic signed [6:0] smp_ff [2];

   // Path 0 is the upper tone, path 1 the lower tone.
   for (genvar p = 0; p < 2; p++)
   begin : g_path
      wire [7:0] code = regs_ff[(p == 0) ? `REG_UPPER : `REG_LOWER];
      wire trig = wr_en && ptr_ff == ((p == 0) ? `REG_UPPER : `REG_LOWER);
      always_ff @(posedge hclk or negedge hresetn)
      begin
         if (!hresetn)
         begin
            ph_ff[p] <= 10'h000;
            smp_ff[p] <= 7'h00;
         end
         else if (trig)
         begin
            ph_ff[p] <= 10'h000;
            smp_ff[p] <= 7'h00;
         end
         else if (tick)
         begin
            ph_ff[p] <= ph_ff[p] + {2'h0, code};
            // A zero code silences the path.
            smp_ff[p] <= (code == 8'h00) ? 7'h00 : sine_lu(ph_ff[p], p == 0);
         end
      end
   end

   // ************************************************************
   // Output ports and buzzer modulator
   // ************************************************************
   wire signed [7:0] mix = {smp_ff[0][6], smp_ff[0]} + {smp_ff[1][6], smp_ff[1]};
   wire [14:0] mix_word = {mix, 7'h00};
   wire [7:0] pdm_in = {~mix[7], mix[6:0]};
   logic [7:0] acc_ff;
   wire [8:0] acc_sum = {1'b0, acc_ff} + {1'b0, pdm_in};

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         ear1_word <= 15'h0000;
         ear2_word <= 15'h0000;
         acc_ff <= 8'h00;
         buzzer_pdm_out <= 1'b0;
      end
      else
      begin
         ear1_word <= regs_ff[`REG_PWR][`EN_EAR1] ? mix_word : 15'h0000;
         ear2_word <= regs_ff[`REG_PWR][`EN_EAR2] ? mix_word : 15'h0000;
         acc_ff <= acc_sum[7:0];
         buzzer_pdm_out <= regs_ff[`REG_PWR][`EN_BUZZ] & acc_sum[8];
      end
   end

endmodule // tone_device

`default_nettype wire

// >>> hdl/tone_defs.svh
`ifndef TONE_DEFS_SVH
`define TONE_DEFS_SVH

`define DEV_ADDR_W 8'hE2
`define DEV_ADDR_R 8'hE3
`define DEV_ADDR7 7'h71
`define REG_COUNT 6
`define REG_PWR 3'h0
`define REG_UPPER 3'h4
`define REG_LOWER 3'h5
`define REG_PWR_RST 8'h07
`define REG_RST 8'h00
`define EN_EAR1 0
`define EN_EAR2 1
`define EN_BUZZ 2
`define CLK_MHZ 25
`define SAMPLE_HZ 8000
`define QTR_NS 2500
`define CTRL_OFS 2'h0
`define STAT_OFS 2'h1
`define CTRL_GO 0
`define CTRL_RD 1
`define CTRL_IDX 8
`define CTRL_DAT 16
`define STAT_BUSY 0
`define STAT_NACK 1
`define STAT_RDAT 8

`endif

// >>> hdl/tone_pkg.sv
package tone_pkg;

   typedef enum logic [4:0] {
      d_idle = 5'h01,
      d_rx = 5'h02,
      d_ack = 5'h04,
      d_tx = 5'h08,
      d_ain = 5'h10
   } dev_state_t;

   typedef enum logic [3:0] {
      h_idle = 4'h1,
      h_start = 4'h2,
      h_bit = 4'h4,
      h_stop = 4'h8
   } host_state_t;

endpackage

// >>> hdl/i2c_link_if.sv
`timescale 1ns/1ps
`default_nettype none

interface i2c_link_if;
   logic scl_o;
   logic scl_oe;
   logic sda_h_o;
   logic sda_h_oe;
   logic sda_d_o;
   logic sda_d_oe;
   logic scl;
   logic sda;

   // Open-drain wires with pull-ups: any driver that is enabled and low wins.
   assign scl = ~(scl_oe & ~scl_o);
   assign sda = ~(sda_h_oe & ~sda_h_o) & ~(sda_d_oe & ~sda_d_o);

   modport host (output scl_o, output scl_oe, output sda_h_o, output sda_h_oe,
                 input scl, input sda);
   modport device (output sda_d_o, output sda_d_oe, input scl, input sda);
endinterface

`default_nettype wire

// >>> hdl/tone_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "tone_defs.svh"

module tone_host (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic hready,
   input wire logic [31:0] hwdata,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   i2c_link_if.host link
);

   // ************************************************************
   // Register slave
   // ************************************************************
   logic wr_ph_ff;
   logic [1:0] ofs_ff;
   logic busy_ff;
   logic nack_ff;
   logic rd_ff;
   logic [2:0] idx_ff;
   logic [7:0] dat_ff;
   logic [7:0] rx_ff;
   logic [7:0] rdat_ff;
   wire aph = hready & hsel & htrans[1];
   wire [1:0] a_ofs = haddr[3:2];
   wire [31:0] ctrl_rd = {8'h00, dat_ff, 5'h00, idx_ff, 6'h00, rd_ff, 1'b0};
   wire [31:0] stat_rd = {16'h0000, rdat_ff, 6'h00, nack_ff, busy_ff};
   wire [31:0] rsel = (a_ofs == `CTRL_OFS) ? ctrl_rd :
                      (a_ofs == `STAT_OFS && haddr[31:4] == 28'h0000000) ? stat_rd : 32'h0;
   // Commands arriving while busy are dropped; software polls busy first.
   wire go = wr_ph_ff && ofs_ff == `CTRL_OFS && hwdata[`CTRL_GO] && !busy_ff;

   assign hreadyout = 1'b1;
   assign hresp = 1'b0;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         wr_ph_ff <= 1'b0;
         ofs_ff <= 2'h0;
         hrdata <= 32'h0;
      end
      else if (hready)
      begin
         wr_ph_ff <= aph & hwrite & haddr[31:4] == 28'h0000000;
         ofs_ff <= a_ofs;
         if (aph & ~hwrite)
            hrdata <= rsel;
      end
   end

   // ************************************************************
   // Serial master
   // ************************************************************
   localparam int QTR = (`QTR_NS * `CLK_MHZ + 999) / 1000;
   logic [6:0] qdiv_ff;
   wire qt = qdiv_ff == 7'(QTR - 1);
   logic [1:0] scl_sync_ff;
   logic [1:0] sda_sync_ff;
   wire sda_s = sda_sync_ff[1];
   wire bus_idle = scl_sync_ff[1] & sda_s;
   tone_pkg::host_state_t st_ff;
   logic [1:0] q_ff;
   logic pass_ff;
   logic [1:0] bidx_ff;
   logic [3:0] bit_ff;
   logic scl_v_ff;
   logic sda_v_ff;
   wire [7:0] txb = pass_ff ? `DEV_ADDR_R :
                    (bidx_ff == 2'h0) ? `DEV_ADDR_W :
                    (bidx_ff == 2'h1) ? {5'h00, idx_ff} : dat_ff;
   wire rxm = pass_ff && bidx_ff == 2'h1;
   wire last = pass_ff ? bidx_ff == 2'h1 : bidx_ff == (rd_ff ? 2'h1 : 2'h2);
   // Receive bytes and every acknowledge slot leave the line released.
   wire bit_out = (bit_ff[3] || rxm) ? 1'b1 : txb[3'h7 - bit_ff[2:0]];

   assign link.scl_o = 1'b0;
   assign link.scl_oe = ~scl_v_ff;
   assign link.sda_h_o = 1'b0;
   assign link.sda_h_oe = ~sda_v_ff;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         qdiv_ff <= 7'h00;
         scl_sync_ff <= 2'h3;
         sda_sync_ff <= 2'h3;
      end
      else
      begin
         qdiv_ff <= qt ? 7'h00 : qdiv_ff + 7'h01;
         scl_sync_ff <= {scl_sync_ff[0], link.scl};
         sda_sync_ff <= {sda_sync_ff[0], link.sda};
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_ff <= tone_pkg::h_idle;
         q_ff <= 2'h0;
         pass_ff <= 1'b0;
         bidx_ff <= 2'h0;
         bit_ff <= 4'h0;
         scl_v_ff <= 1'b1;
         sda_v_ff <= 1'b1;
         busy_ff <= 1'b0;
         nack_ff <= 1'b0;
         rd_ff <= 1'b0;
         idx_ff <= 3'h0;
         dat_ff <= 8'h00;
         rx_ff <= 8'h00;
         rdat_ff <= 8'h00;
      end
      else
      begin
         case (st_ff)
            tone_pkg::h_idle:
            begin
               if (go)
               begin
                  busy_ff <= 1'b1;
                  nack_ff <= 1'b0;
                  rd_ff <= hwdata[`CTRL_RD];
                  idx_ff <= hwdata[`CTRL_IDX +: 3];
                  dat_ff <= hwdata[`CTRL_DAT +: 8];
                  pass_ff <= 1'b0;
                  q_ff <= 2'h0;
                  st_ff <= tone_pkg::h_start;
               end
            end
            tone_pkg::h_start:
            begin
               if (qt && (q_ff != 2'h0 || bus_idle))
               begin
                  q_ff <= q_ff + 2'h1;
                  if (q_ff == 2'h1)
                     sda_v_ff <= 1'b0;
                  if (q_ff == 2'h2)
                     scl_v_ff <= 1'b0;
                  if (q_ff == 2'h3)
                  begin
                     bidx_ff <= 2'h0;
                     bit_ff <= 4'h0;
                     st_ff <= tone_pkg::h_bit;
                  end
               end
            end
            tone_pkg::h_bit:
            begin
               if (qt)
               begin
                  q_ff <= q_ff + 2'h1;
                  case (q_ff)
                     2'h0: sda_v_ff <= bit_out;
                     2'h1: scl_v_ff <= 1'b1;
                     2'h2:
                     begin
                        if (rxm && !bit_ff[3])
                           rx_ff <= {rx_ff[6:0], sda_s};
                        if (bit_ff[3] && !rxm && sda_s)
                           nack_ff <= 1'b1;
                     end
                     default:
                     begin
                        scl_v_ff <= 1'b0;
                        bit_ff <= bit_ff + 4'h1;
                        if (bit_ff[3])
                        begin
                           bit_ff <= 4'h0;
                           bidx_ff <= bidx_ff + 2'h1;
                           if (last || nack_ff)
                              st_ff <= tone_pkg::h_stop;
                        end
                     end
                  endcase
               end
            end
            tone_pkg::h_stop:
            begin
               if (qt)
               begin
                  q_ff <= q_ff + 2'h1;
                  if (q_ff == 2'h0)
                     sda_v_ff <= 1'b0;
                  if (q_ff == 2'h1)
                     scl_v_ff <= 1'b1;
                  if (q_ff == 2'h2)
                     sda_v_ff <= 1'b1;
                  if (q_ff == 2'h3)
                  begin
                     if (rd_ff && !pass_ff && !nack_ff)
                     begin
                        pass_ff <= 1'b1;
                        st_ff <= tone_pkg::h_start;
                     end
                     else
                     begin
                        busy_ff <= 1'b0;
                        rdat_ff <= rx_ff;
                        st_ff <= tone_pkg::h_idle;
                     end
                  end
               end
            end
            default:
               st_ff <= tone_pkg::h_idle;
         endcase
      end
   end

endmodule // tone_host

`default_nettype wire

// >>> sim/i2c_link_sva.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_link_sva (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sda_d_oe,
   input wire logic scl,
   input wire logic sda
);
   // ****************************************
   // Bit and byte tracking.
   // ****************************************
   logic scl_q_ff, sda_q_ff, first_ff, rd_ff, st_ff;
   logic nxt_first, nxt_rd, nxt_st;
   logic [3:0] bit_ff, nxt_bit;
   logic [7:0] sh_ff, nxt_sh, hi_ff, nxt_hi;
   wire logic rise = scl & ~scl_q_ff;
   wire logic strt = scl & scl_q_ff & sda_q_ff & ~sda;
   wire logic ack = rise & (bit_ff == 4'h8);

   assign nxt_bit = (strt | ack) ? 4'h0 : rise ? bit_ff + 4'h1 : bit_ff;
   assign nxt_first = strt | (first_ff & ~ack);
   assign nxt_rd = (ack & first_ff) ? sh_ff[0] : rd_ff;
   // A clock fall right after a start is skipped, since the idle high time is unknown.
   assign nxt_st = strt | (st_ff & ~rise);
   assign nxt_sh = (rise & ~bit_ff[3]) ? {sh_ff[6:0], sda} : sh_ff;
   assign nxt_hi = !scl ? 8'h00 : (&hi_ff) ? hi_ff : hi_ff + 8'h01;

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         scl_q_ff <= 1'b1;
         sda_q_ff <= 1'b1;
         {first_ff, rd_ff, st_ff, bit_ff, sh_ff, hi_ff} <= '0;
      end
      else
      begin
         scl_q_ff <= scl;
         sda_q_ff <= sda;
         {first_ff, rd_ff, st_ff, bit_ff, sh_ff, hi_ff} <=
            {nxt_first, nxt_rd, nxt_st, nxt_bit, nxt_sh, nxt_hi};
      end
   end

   // ****************************************
   // Protocol checks.
   // ****************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   sequence s_start;
      scl && $past(scl) && $fell(sda);
   endsequence

   sequence s_stop;
      scl && $past(scl) && $rose(sda);
   endsequence

   AST_START_IDLE: assert property (s_start |-> $past(sda, 40) && $past(scl, 40))
      else $error("start on busy bus");
   AST_STOP_FREE: assert property (s_stop |-> !sda_d_oe ##1 (scl && sda) [*8])
      else $error("bus not free after stop");
   AST_DEV_EDGE: assert property ($changed(sda_d_oe) |-> !scl && !$past(scl))
      else $error("device data changed with clock high");
   AST_ADDR: assert property (ack && first_ff |-> sh_ff[7:1] == 7'h71 && sda_d_oe)
      else $error("address byte wrong or not acked");
   AST_WR_ACK: assert property (ack && !first_ff && !rd_ff |-> sda_d_oe)
      else $error("byte not acked");
   AST_RD_FREE: assert property (ack && !first_ff && rd_ff |-> !sda_d_oe)
      else $error("device held data in master ack slot");
   AST_ACK_LOW: assert property (ack && sda_d_oe |-> (sda_d_oe && !sda) [*8])
      else $error("ack not held low");
   AST_SCL_HIGH: assert property ($fell(scl) && !st_ff |-> hi_ff == 8'h7E)
      else $error("clock high phase length wrong");
endmodule // i2c_link_sva

`default_nettype wire

// >>> sim/i2c_tone_control_test.sv
`timescale 1ns/1ps
`default_nettype none

module i2c_tone_control_test;
   logic hclk, hresetn, hsel, hwrite, hready, hresp, buzz, tick;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [14:0] ear1, ear2;
   int fails, checks;

   i2c_link_if link ();
   tone_host u_tone_host (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata),
      .hreadyout(hready), .hrdata(hrdata), .hresp(hresp), .link(link));
   tone_device u_tone_device (.hclk(hclk), .hresetn(hresetn), .link(link), .ear1_word(ear1),
      .ear2_word(ear2), .buzzer_pdm_out(buzz), .sample_tick(tick));
   i2c_link_sva u_i2c_link_sva (.hclk(hclk), .hresetn(hresetn), .sda_d_oe(link.sda_d_oe),
      .scl(link.scl), .sda(link.sda));

   initial
   begin
      hclk = 1'b0;
      forever #20 hclk = ~hclk;
   end

   // ****************************************
   // Bus and compare tasks.
   // ****************************************
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp)
      begin
         fails++;
         $display("ERROR %0t got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d,
      output logic [31:0] q);
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= wr;
      htrans <= 2'h2;
      do @(posedge hclk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hready !== 1'b1);
      q = hrdata;
   endtask

   task automatic link_op(input logic rd, input logic [2:0] idx, input logic [7:0] dat,
      output logic [31:0] st);
      int n;
      ahb(1'b1, 32'h0, {8'h00, dat, 5'h00, idx, 6'h00, rd, 1'b1}, st);
      n = 0;
      st = 32'h1;
      while (st[0] !== 1'b0 && n < 8000)
      begin
         ahb(1'b0, 32'h4, 32'h0, st);
         n++;
      end
      // A link that never goes idle ends the run here rather than poisoning later checks.
      if (st[0] !== 1'b0)
      begin
         fails++;
         $display("ERROR %0t link operation never finished", $time);
         tally_and_finish();
      end
   endtask

   // ****************************************
   // Scenarios.
   // ****************************************
   task automatic test_regs();
      logic [31:0] st;
      link_op(1'b1, 3'h0, 8'h00, st);
      chk({16'h0000, st[15:0]}, 32'h0000_0700);
      link_op(1'b0, 3'h4, 8'h9B, st);
      chk(st & 32'h3, 32'h0);
      link_op(1'b0, 3'h5, 8'h59, st);
      link_op(1'b1, 3'h4, 8'h00, st);
      chk({16'h0000, st[15:0]}, 32'h0000_9B00);
      ahb(1'b0, 32'h8, 32'h0, st);
      chk(st, 32'h0);
      chk({31'h0, hresp}, 32'h0);
      $display("test_regs done");
   endtask

   task automatic test_tone();
      int n, hi;
      logic [6:0] pad;
      logic same, rng, nz;
      logic [31:0] st;
      // Outputs are sampled on the falling edge, where they have settled.
      do @(negedge hclk); while (tick !== 1'b1);
      n = 0;
      do
      begin
         @(negedge hclk);
         n++;
      end
      while (tick !== 1'b1);
      chk(n, 32'h0C35);
      {pad, same, rng, nz, hi} = {7'h00, 1'b1, 1'b1, 1'b0, 32'h0};
      repeat (12500)
      begin
         @(negedge hclk);
         pad = pad | ear1[6:0];
         same = same & (ear1 === ear2);
         rng = rng & ((ear1 <= 15'h2300) || (ear1 >= 15'h5C00));
         nz = nz | (ear1 != 15'h0000);
         hi = hi + buzz;
      end
      chk(pad, 32'h0);
      chk(same, 32'h1);
      chk(rng, 32'h1);
      chk(nz, 32'h1);
      chk(hi > 0, 32'h1);
      // Bus requests must start right after a rising edge, not from the sampling edge.
      @(posedge hclk);
      link_op(1'b0, 3'h0, 8'h00, st);
      do @(negedge hclk); while (tick !== 1'b1);
      repeat (3) @(negedge hclk);
      chk({ear1, ear2, buzz}, 32'h0);
      $display("test_tone done");
   endtask

   task automatic tally_and_finish();
      $display("checks %0d fails %0d", checks, fails);
      if (fails == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      {hresetn, hsel, hwrite, htrans, hsize} = {1'b0, 1'b0, 1'b0, 2'h0, 3'h2};
      {haddr, hwdata} = {32'h0, 32'h0};
      fails = 0;
      checks = 0;
      repeat (12) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      test_regs();
      test_tone();
      tally_and_finish();
   end

   initial
   begin
      repeat (95000) @(posedge hclk);
      fails++;
      $display("ERROR %0t watchdog expired", $time);
      tally_and_finish();
   end
endmodule // i2c_tone_control_test

`default_nettype wire
